// ### rtl/char_fifo.sv
// Transmit character FIFO with a run-time depth limit.
// Assumes one clock; limit is at least 1 and at most DEPTH.
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [$clog2(DEPTH+1)-1:0] limit,
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [WIDTH-1:0]                out_data,
  input  wire logic                       out_ready
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [IW-1:0]    wr_idx;
  logic [IW-1:0]    rd_idx;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  function automatic logic [IW-1:0] bump(input logic [IW-1:0] idx);
    bump = (idx == IW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction

  assign in_ready  = count < limit;
  assign out_valid = count != '0;
  assign out_data  = store[rd_idx];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= bump(wr_idx);
      end
      if (pop) begin
        rd_idx <= bump(rd_idx);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_idx] <= in_data;
    end
  end
endmodule

// ### rtl/uart_char_device.sv
// Channel end: multidrop address filter, control character table, hunt/sleep handling
// and out-of-sequence character insertion ahead of buffered transmit data.
// Assumes an Avalon-MM master on sys_clk and a remote station on the serial_char_if link.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module uart_char_device #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  serial_char_if.device    link,
  input  wire logic        buf_valid,
  input  wire logic [7:0]  buf_char,
  output logic             buf_ready,
  output logic             buf_cts_lost,
  output logic             store_valid,
  output logic [7:0]       store_char,
  output logic             store_new_buffer,
  output logic [1:0]       store_match,
  output logic             buffer_close,
  output logic             close_on_ctrl
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  logic [15:0] addr1;
  logic [15:0] addr2;
  logic [15:0] mask;
  logic [15:0] rcc_hold;
  logic [15:0] oos_entry;
  logic [15:0] ctrl;
  logic [15:0] brk_count;
  logic [15:0] table_q [uart_char_pkg::TABLE_SIZE];
  logic [4:0]  events;
  logic        rd_ack;
  uart_char_pkg::rx_state_type rx_state;
  logic        buf_open;
  logic        accept;
  logic [1:0]  match_id;
  logic        oos_queued;
  logic        cts_seen;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data, input logic [3:0] be);
    merge = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
  endfunction

  // Returns {hit, reject} for the first valid entry that matches under the mask
  function automatic logic [1:0] ctrl_lookup(input logic [7:0] ch);
    logic stop;
    stop = 1'b0;
    ctrl_lookup = 2'b00;
    for (int i = 0; i < uart_char_pkg::TABLE_SIZE; i++) begin
      if (table_q[i][uart_char_pkg::ENTRY_END]) begin
        stop = 1'b1;
      end
      if (!stop && !ctrl_lookup[1] && (((table_q[i][7:0] ^ ch) & mask[7:0]) == 8'h00)) begin
        ctrl_lookup = {1'b1, table_q[i][uart_char_pkg::ENTRY_REJ]};
      end
    end
  endfunction

  // Register bus: writes complete at once, reads take one wait cycle
  logic wr;
  logic on_table;
  logic cmd_hunt;
  logic cmd_close;
  assign wr        = avs_write;
  assign on_table  = avs_address[7:5] == uart_char_pkg::TABLE_PAGE;
  assign cmd_hunt  = wr && avs_address == uart_char_pkg::OFF_CTRL && avs_byteenable[1]
                     && avs_writedata[uart_char_pkg::CTRL_HUNT];
  assign cmd_close = wr && avs_address == uart_char_pkg::OFF_CTRL && avs_byteenable[1]
                     && avs_writedata[uart_char_pkg::CTRL_CLOSE];
  assign avs_waitrequest = avs_read && !rd_ack;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack       <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        avs_readdata <= '0;
        if (on_table) begin
          avs_readdata[15:0] <= table_q[avs_address[4:2]];
        end else begin
          unique case (avs_address)
            uart_char_pkg::OFF_ADDR1:  avs_readdata[15:0] <= addr1;
            uart_char_pkg::OFF_ADDR2:  avs_readdata[15:0] <= addr2;
            uart_char_pkg::OFF_MASK:   avs_readdata[15:0] <= mask;
            uart_char_pkg::OFF_REJECT: avs_readdata[15:0] <= rcc_hold;
            uart_char_pkg::OFF_OOS:    avs_readdata[15:0] <= oos_entry;
            uart_char_pkg::OFF_CTRL:   avs_readdata[15:0] <= {8'h00, ctrl[7:0]};
            uart_char_pkg::OFF_STATUS: avs_readdata[15:0] <= {3'b000, events, 7'h00,
                                                              rx_state == uart_char_pkg::RX_HUNT};
            uart_char_pkg::OFF_BREAK:  avs_readdata[15:0] <= brk_count;
            default:                   avs_readdata <= '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr1 <= uart_char_pkg::ZERO_RESET;
      addr2 <= uart_char_pkg::ZERO_RESET;
      mask  <= uart_char_pkg::MASK_RESET;
      ctrl  <= uart_char_pkg::CTRL_RESET;
      for (int i = 0; i < uart_char_pkg::TABLE_SIZE; i++) begin
        table_q[i] <= uart_char_pkg::ENTRY_RESET;
      end
    end else if (wr) begin
      if (on_table) begin
        table_q[avs_address[4:2]] <= merge(table_q[avs_address[4:2]], avs_writedata, avs_byteenable);
      end
      unique case (avs_address)
        uart_char_pkg::OFF_ADDR1: addr1 <= merge(addr1, avs_writedata, avs_byteenable);
        uart_char_pkg::OFF_ADDR2: addr2 <= merge(addr2, avs_writedata, avs_byteenable);
        uart_char_pkg::OFF_MASK:  mask <= merge(mask, avs_writedata, avs_byteenable);
        uart_char_pkg::OFF_CTRL:  ctrl <= {8'h00, avs_byteenable[0] ? avs_writedata[7:0] : ctrl[7:0]};
        default: ;
      endcase
    end
  end

  // Receive side
  logic       md_auto;
  logic       wake_addr;
  logic       hunt_wake;
  logic       take;
  logic       addr_char;
  logic [1:0] lookup;
  logic       brk_hit;
  assign md_auto   = ctrl[uart_char_pkg::CTRL_MD_EN] && ctrl[uart_char_pkg::CTRL_MD_AUTO];
  assign wake_addr = ctrl[uart_char_pkg::CTRL_WAKE_ADDR];
  assign addr_char = ctrl[uart_char_pkg::CTRL_MD_EN] && link.rx_addr_bit;
  assign hunt_wake = rx_state == uart_char_pkg::RX_HUNT
                     && (wake_addr ? (link.rx_valid && link.rx_addr_bit) : link.rx_idle);
  assign take      = link.rx_valid && (rx_state == uart_char_pkg::RX_ACTIVE || (hunt_wake && wake_addr));
  // A continuous assignment would miss table and mask writes read inside the function
  always_comb begin
    lookup = ctrl_lookup(link.rx_char);
  end
  assign brk_hit   = rx_state == uart_char_pkg::RX_HUNT && link.rx_break;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state         <= uart_char_pkg::RX_ACTIVE;
      buf_open         <= 1'b0;
      accept           <= 1'b0;
      match_id         <= 2'b00;
      store_valid      <= 1'b0;
      store_char       <= 8'h00;
      store_new_buffer <= 1'b0;
      store_match      <= 2'b00;
      buffer_close     <= 1'b0;
      close_on_ctrl    <= 1'b0;
    end else begin
      store_valid      <= 1'b0;
      store_new_buffer <= 1'b0;
      buffer_close     <= 1'b0;
      close_on_ctrl    <= 1'b0;
      if (cmd_hunt || cmd_close) begin
        buffer_close <= buf_open;
        buf_open     <= 1'b0;
        if (cmd_hunt) begin
          rx_state <= uart_char_pkg::RX_HUNT;
          accept   <= 1'b0;
        end
      end else begin
        if (hunt_wake) begin
          rx_state <= uart_char_pkg::RX_ACTIVE;
        end
        if (take) begin
          store_char  <= link.rx_char;
          store_match <= md_auto ? match_id : 2'b00;
          if (addr_char && md_auto) begin
            accept   <= link.rx_char == addr1[7:0] || link.rx_char == addr2[7:0];
            match_id <= {link.rx_char == addr2[7:0], link.rx_char == addr1[7:0]};
          end else if (addr_char) begin
            store_valid      <= 1'b1;
            store_new_buffer <= 1'b1;
            buf_open         <= 1'b1;
          end else if (!md_auto || accept) begin
            if (lookup == 2'b10) begin
              store_valid      <= 1'b1;
              store_new_buffer <= !buf_open;
              buffer_close     <= 1'b1;
              close_on_ctrl    <= 1'b1;
              buf_open         <= 1'b0;
            end else if (lookup != 2'b11) begin
              store_valid      <= 1'b1;
              store_new_buffer <= !buf_open;
              buf_open         <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Rejected characters overwrite the hold register; software reads it before the next one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcc_hold <= uart_char_pkg::ZERO_RESET;
    end else if (take && !addr_char && (!md_auto || accept) && lookup == 2'b11) begin
      rcc_hold <= {8'h00, link.rx_char};
    end else if (wr && avs_address == uart_char_pkg::OFF_REJECT) begin
      rcc_hold <= merge(rcc_hold, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_count <= uart_char_pkg::ZERO_RESET;
    end else if (brk_hit) begin
      brk_count <= brk_count + 16'h0001;
    end else if (wr && avs_address == uart_char_pkg::OFF_BREAK) begin
      brk_count <= merge(brk_count, avs_writedata, avs_byteenable);
    end
  end

  // Transmit side
  logic            tx_en;
  logic            oos_push;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic [9:0]      fifo_out_data;
  logic            head_oos;
  logic            oos_done;
  logic            cts_bad;
  logic            lost;
  logic [CW-1:0]   fifo_limit;
  assign tx_en      = ctrl[uart_char_pkg::CTRL_TX_EN];
  assign oos_push   = tx_en && oos_entry[uart_char_pkg::OOS_READY] && !oos_queued;
  assign buf_ready  = tx_en && !oos_push && fifo_in_ready;
  assign fifo_limit = ctrl[uart_char_pkg::CTRL_SHRINK] ? CW'(1) : CW'(FIFO_DEPTH);
  assign head_oos   = fifo_out_valid && fifo_out_data[9];
  assign oos_done   = head_oos && link.tx_ready;
  assign cts_bad    = ctrl[uart_char_pkg::CTRL_MON_CTS] && link.cts_n;
  assign lost       = cts_seen || (head_oos && cts_bad);
  assign link.tx_valid   = fifo_out_valid;
  assign link.tx_char    = fifo_out_data[7:0];
  assign link.tx_addr_bit = fifo_out_data[8];

  char_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) tx_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .limit     (fifo_limit),
    .in_valid  (oos_push || (tx_en && buf_valid)),
    .in_data   (oos_push ? {1'b1, oos_entry[uart_char_pkg::OOS_ADDR], oos_entry[7:0]} : {2'b00, buf_char}),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (link.tx_ready)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oos_queued <= 1'b0;
      cts_seen   <= 1'b0;
    end else begin
      if (oos_push && fifo_in_ready) begin
        oos_queued <= 1'b1;
      end else if (oos_done) begin
        oos_queued <= 1'b0;
      end
      cts_seen <= oos_done ? 1'b0 : lost;
    end
  end

  // Hardware update applied after a software write so that a completion is never lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oos_entry <= uart_char_pkg::ZERO_RESET;
    end else begin
      logic [15:0] next_entry;
      next_entry = oos_entry;
      if (wr && avs_address == uart_char_pkg::OFF_OOS) begin
        next_entry = merge(oos_entry, avs_writedata, avs_byteenable);
      end
      if (oos_done) begin
        next_entry[uart_char_pkg::OOS_READY] = 1'b0;
        if (lost) begin
          next_entry[uart_char_pkg::OOS_CT] = 1'b1;
        end
      end
      oos_entry <= next_entry;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_cts_lost <= 1'b0;
    end else begin
      buf_cts_lost <= oos_done && lost && buf_valid;
    end
  end

  // Sticky events, write one to clear; a new event in the clearing cycle survives
  logic [4:0] ev_set;
  assign ev_set = {close_on_ctrl,
                   take && !addr_char && (!md_auto || accept) && lookup == 2'b11,
                   brk_hit,
                   oos_done && lost,
                   oos_done && oos_entry[uart_char_pkg::OOS_INT]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      events <= 5'h00;
    end else if (wr && avs_address == uart_char_pkg::OFF_STATUS && avs_byteenable[1]) begin
      events <= (events & ~avs_writedata[12:8]) | ev_set;
    end else begin
      events <= events | ev_set;
    end
  end
endmodule

// ### rtl/uart_char_station.sv
// Remote station end: turns user character requests into link strobes and
// hands characters sent by the channel back to its user.
// Assumes the channel on the same sys_clk through serial_char_if.
`timescale 1ns/1ps
module uart_char_station (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  serial_char_if.station  link,
  input  wire logic       send_valid,
  input  wire logic [7:0] send_char,
  input  wire logic       send_addr_bit,
  input  wire logic       send_idle,
  input  wire logic       send_break,
  input  wire logic       cts_negate,
  input  wire logic       recv_ready,
  output logic            recv_valid,
  output logic [7:0]      recv_char,
  output logic            recv_addr_bit
);
  // A break wins over any character offered in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.rx_valid    <= 1'b0;
      link.rx_char     <= 8'h00;
      link.rx_addr_bit <= 1'b0;
      link.rx_idle     <= 1'b0;
      link.rx_break    <= 1'b0;
      link.cts_n       <= 1'b0;
    end else begin
      link.rx_break    <= send_break;
      link.rx_idle     <= send_idle && !send_break;
      link.rx_valid    <= send_valid && !send_break && !send_idle;
      link.rx_char     <= send_char;
      link.rx_addr_bit <= send_addr_bit;
      link.cts_n       <= cts_negate;
    end
  end

  assign link.tx_ready = recv_ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      recv_valid    <= 1'b0;
      recv_char     <= 8'h00;
      recv_addr_bit <= 1'b0;
    end else begin
      recv_valid <= link.tx_valid && recv_ready;
      if (link.tx_valid && recv_ready) begin
        recv_char     <= link.tx_char;
        recv_addr_bit <= link.tx_addr_bit;
      end
    end
  end
endmodule

// ### shared/serial_char_if.sv
// Character-level multidrop serial link between the channel and a remote station.
// Both ends run on the same sys_clk; every strobe is a one-cycle pulse except the tx handshake.
`timescale 1ns/1ps
interface serial_char_if;
  logic       rx_valid;
  logic [7:0] rx_char;
  logic       rx_addr_bit;
  logic       rx_idle;
  logic       rx_break;
  logic       tx_valid;
  logic [7:0] tx_char;
  logic       tx_addr_bit;
  logic       tx_ready;
  logic       cts_n;

  modport device (
    input  rx_valid,
    input  rx_char,
    input  rx_addr_bit,
    input  rx_idle,
    input  rx_break,
    output tx_valid,
    output tx_char,
    output tx_addr_bit,
    input  tx_ready,
    input  cts_n
  );

  modport station (
    output rx_valid,
    output rx_char,
    output rx_addr_bit,
    output rx_idle,
    output rx_break,
    input  tx_valid,
    input  tx_char,
    input  tx_addr_bit,
    output tx_ready,
    output cts_n
  );
endinterface

// ### shared/uart_char_pkg.sv
// Shared constants for the character-level multidrop UART filter and out-of-sequence transmit path.
// Assumes 32-bit Avalon-MM register access with byte addresses and 16-bit registers in the low half.
package uart_char_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TABLE_SIZE = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_ADDR1 = 8'h00;
  localparam logic [7:0] OFF_ADDR2 = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_REJECT = 8'h0C;
  localparam logic [7:0] OFF_OOS = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_BREAK = 8'h1C;
  localparam logic [2:0] TABLE_PAGE = 3'h1;

  // Control register bits
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_MD_EN = 1;
  localparam int CTRL_MD_AUTO = 2;
  localparam int CTRL_WAKE_ADDR = 3;
  localparam int CTRL_MON_CTS = 4;
  localparam int CTRL_SHRINK = 5;
  localparam int CTRL_HUNT = 8;
  localparam int CTRL_CLOSE = 9;

  // Status register bits
  localparam int ST_HUNTING = 0;
  localparam int ST_EV_TX = 8;
  localparam int ST_EV_CTS = 9;
  localparam int ST_EV_BRK = 10;
  localparam int ST_EV_REJ = 11;
  localparam int ST_EV_CTRL = 12;

  // Control character entry fields
  localparam int ENTRY_END = 15;
  localparam int ENTRY_REJ = 14;

  // Out-of-sequence entry fields
  localparam int OOS_READY = 13;
  localparam int OOS_INT = 12;
  localparam int OOS_CT = 11;
  localparam int OOS_ADDR = 8;

  // Values after reset
  localparam logic [15:0] ENTRY_RESET = 16'h8000;
  localparam logic [15:0] MASK_RESET = 16'hC0FF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;

  typedef enum logic {RX_ACTIVE, RX_HUNT} rx_state_type;

endpackage

// ### verification/uart_char_link_chk.sv
// Link checker for the serial_char_if joining the channel and the station.
// Assumes one clock domain and the active-low asynchronous reset of both ends.
`timescale 1ns/1ps
module uart_char_link_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       rx_valid,
  input wire logic       rx_idle,
  input wire logic       rx_break,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_char,
  input wire logic       tx_addr_bit,
  input wire logic       tx_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx_valid dropped untaken");
  property p_char_hold;
    tx_valid && !tx_ready |=> $stable(tx_char);
  endproperty
  a_char_hold: assert property (p_char_hold) else $error("tx_char changed untaken");
  property p_addr_hold;
    tx_valid && !tx_ready |=> tx_addr_bit == $past(tx_addr_bit);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("tx_addr_bit changed untaken");
  property p_fall_taken;
    $fell(tx_valid) |-> $past(tx_ready);
  endproperty
  a_fall_taken: assert property (p_fall_taken) else $error("tx_valid fell without a take");
  property p_brk_alone;
    rx_break |-> !rx_idle && !rx_valid;
  endproperty
  a_brk_alone: assert property (p_brk_alone) else $error("break shares a cycle");
  property p_idle_alone;
    rx_idle |-> !rx_valid;
  endproperty
  a_idle_alone: assert property (p_idle_alone) else $error("idle shares a cycle");
  property p_tx_reset;
    $rose(rst_n) |-> !tx_valid;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx_valid high after reset");
  property p_rx_reset;
    $rose(rst_n) |-> !(rx_valid || rx_idle || rx_break);
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("rx strobe after reset");
endmodule

// ### verification/uart_rx_filter_oos_tx_bench.sv
// Bench: channel and station joined by serial_char_if, registers over Avalon-MM.
// Assumes the register map of uart_char_pkg; the buffer side is left idle.
`timescale 1ns/1ps
module uart_rx_filter_oos_tx_bench;
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        s_valid = 1'h0, s_addr = 1'h0, s_idle = 1'h0, s_break = 1'h0, recv_ready = 1'h1;
  logic [7:0]  s_char = 8'h00, last_char, last_recv;
  logic        store_valid, store_new_buffer, buffer_close, close_on_ctrl, recv_valid, last_new;
  logic [7:0]  store_char, recv_char;
  logic [1:0]  store_match, last_match;
  logic [31:0] q;
  logic        cts_neg = 1'h0, recv_addr;
  int          fail_count = 0, tests_run = 0, stores = 0, ctrls = 0, closes = 0, recvs = 0;
  serial_char_if link ();
  uart_char_device i_uart_char_device (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link), .buf_valid(1'h0),
    .buf_char(8'h00), .buf_ready(), .buf_cts_lost(), .store_valid(store_valid), .store_char(store_char),
    .store_new_buffer(store_new_buffer), .store_match(store_match), .buffer_close(buffer_close),
    .close_on_ctrl(close_on_ctrl));
  uart_char_station i_uart_char_station (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .send_valid(s_valid), .send_char(s_char), .send_addr_bit(s_addr), .send_idle(s_idle),
    .send_break(s_break), .cts_negate(cts_neg), .recv_ready(recv_ready), .recv_valid(recv_valid),
    .recv_char(recv_char), .recv_addr_bit(recv_addr));
  uart_char_link_chk i_uart_char_link_chk (.sys_clk(sys_clk), .rst_n(rst_n), .rx_valid(link.rx_valid),
    .rx_idle(link.rx_idle), .rx_break(link.rx_break), .tx_valid(link.tx_valid), .tx_char(link.tx_char),
    .tx_addr_bit(link.tx_addr_bit), .tx_ready(link.tx_ready));
  always #2 sys_clk = !sys_clk;
  always @(posedge sys_clk) begin
    if (store_valid) begin
      stores++;
      last_char = store_char;
      last_match = store_match;
      last_new = store_new_buffer;
    end
    if (close_on_ctrl) ctrls++;
    if (buffer_close) closes++;
    if (recv_valid) begin
      recvs++;
      last_recv = recv_char;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, released at that edge, then one more edge waited
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'h1, a, 32'h0);
    check(q & m, e);
  endtask
  task automatic send(input logic [7:0] c, input logic ab, input logic idl, input logic brk);
    s_valid <= !idl && !brk;
    s_char <= c;
    s_addr <= ab;
    s_idle <= idl;
    s_break <= brk;
    @(posedge sys_clk);
    s_valid <= 1'h0;
    s_idle <= 1'h0;
    s_break <= 1'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rdc(8'h08, 32'hFFFFFFFF, 32'h0000C0FF);
    rdc(8'h20, 32'hFFFFFFFF, 32'h00008000);
    rdc(8'h40, 32'hFFFFFFFF, 32'h00000000);
    bus(1'h0, 8'h00, 32'h12);
    bus(1'h0, 8'h04, 32'h34);
    bus(1'h0, 8'h14, 32'h07);
    send(8'h12, 1'h1, 1'h0, 1'h0);
    send(8'h55, 1'h0, 1'h0, 1'h0);
    check({stores[21:0], last_char, last_match}, {22'h1, 8'h55, 2'h1});
    send(8'h34, 1'h1, 1'h0, 1'h0);
    send(8'h66, 1'h0, 1'h0, 1'h0);
    check({stores[21:0], last_char, last_match}, {22'h2, 8'h66, 2'h2});
    send(8'h77, 1'h1, 1'h0, 1'h0);
    send(8'h01, 1'h0, 1'h0, 1'h0);
    check(stores, 32'h2);
    bus(1'h0, 8'h14, 32'h03);
    send(8'h20, 1'h1, 1'h0, 1'h0);
    check({stores[20:0], last_char, last_new, last_match}, {21'h3, 8'h20, 1'h1, 2'h0});
    $display("multidrop test done");
    bus(1'h0, 8'h14, 32'h01);
    bus(1'h0, 8'h20, 32'h0003);
    bus(1'h0, 8'h24, 32'h4013);
    bus(1'h0, 8'h2C, 32'h0044);
    send(8'h03, 1'h0, 1'h0, 1'h0);
    check({stores[15:0], ctrls[15:0]}, {16'h4, 16'h1});
    send(8'h13, 1'h0, 1'h0, 1'h0);
    check(stores, 32'h4);
    rdc(8'h0C, 32'hFFFF, 32'h13);
    rdc(8'h18, 32'h800, 32'h800);
    bus(1'h0, 8'h08, 32'hC0FE);
    send(8'h12, 1'h0, 1'h0, 1'h0);
    rdc(8'h0C, 32'hFFFF, 32'h12);
    send(8'h44, 1'h0, 1'h0, 1'h0);
    check({stores[15:0], ctrls[15:0]}, {16'h5, 16'h1});
    $display("control character test done");
    bus(1'h0, 8'h14, 32'h0101);
    rdc(8'h18, 32'h1, 32'h1);
    send(8'h41, 1'h0, 1'h0, 1'h0);
    send(8'h00, 1'h0, 1'h0, 1'h1);
    check(stores, 32'h5);
    rdc(8'h1C, 32'hFFFF, 32'h1);
    rdc(8'h18, 32'h400, 32'h400);
    send(8'h00, 1'h0, 1'h1, 1'h0);
    send(8'h42, 1'h0, 1'h0, 1'h0);
    check({stores[23:0], last_char}, {24'h6, 8'h42});
    bus(1'h0, 8'h14, 32'h0201);
    send(8'h43, 1'h0, 1'h0, 1'h0);
    check({stores[22:0], last_char, last_new}, {23'h7, 8'h43, 1'h1});
    bus(1'h0, 8'h14, 32'h010B);
    send(8'h45, 1'h0, 1'h0, 1'h0);
    send(8'h46, 1'h1, 1'h0, 1'h0);
    check({stores[22:0], last_char, last_new}, {23'h8, 8'h46, 1'h1});
    $display("hunt test done");
    recv_ready <= 1'h0;
    bus(1'h0, 8'h10, 32'h305A);
    repeat (4) @(posedge sys_clk);
    check(recvs, 32'h0);
    recv_ready <= 1'h1;
    repeat (4) @(posedge sys_clk);
    check({recvs[23:0], last_recv}, {24'h1, 8'h5A});
    rdc(8'h10, 32'h2000, 32'h0);
    rdc(8'h18, 32'h100, 32'h100);
    $display("out-of-sequence test done");
    cts_neg <= 1'h1;
    recv_ready <= 1'h0;
    bus(1'h0, 8'h14, 32'h11);
    bus(1'h0, 8'h10, 32'h2155);
    rdc(8'h10, 32'h2000, 32'h2000);
    recv_ready <= 1'h1;
    repeat (4) @(posedge sys_clk);
    check({recvs[22:0], last_recv, recv_addr}, {23'h2, 8'h55, 1'h1});
    rdc(8'h10, 32'h2800, 32'h0800);
    rdc(8'h18, 32'h200, 32'h200);
    $display("send permission test done");
    results();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    results();
  end
endmodule
